// ---- core/tbt_pkg.sv ----
// Package: constants, register map and carrier types of the timebase interval timer
package tbt_pkg;

  // ----------------------------------------------------------------
  // Counter geometry
  // ----------------------------------------------------------------
  localparam int CNT_W = 21;

  // Clock rate of hclk, taken as the main oscillator frequency
  localparam int HCLK_PERIOD_NS = 25;
  // Count clock is the oscillator divided by two
  localparam int COUNT_DIV = 2;

  // Tap bit = log2(period in oscillator cycles) - 2, since the count clock is osc/2
  // and a bit's carry-out recurs every 2^(bit+1) count clocks.
  // Interval select 00..11: 2^13, 2^15, 2^18, 2^21 oscillator periods
  localparam int IVL_BIT0 = 11;
  localparam int IVL_BIT1 = 13;
  localparam int IVL_BIT2 = 16;
  localparam int IVL_BIT3 = 19;
  // Stabilisation wait select 00..11: 2^14, 2^15, 2^17, 2^18 oscillator periods
  localparam int WAIT_BIT0 = 12;
  localparam int WAIT_BIT1 = 13;
  localparam int WAIT_BIT2 = 15;
  localparam int WAIT_BIT3 = 16;
  // Peripheral clock taps: counter bits whose full period matches each consumer
  localparam int TAP_WDT = 14;
  localparam int TAP_BUZ = 16;
  localparam int TAP_ADC = 14;
  localparam int TAP_LCD = 14;

  // ----------------------------------------------------------------
  // Register map (byte addresses; control sits at index 0x0a)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_TBC = 8'h0a;
  localparam logic [7:0] ADDR_TBC = 8'h28;
  localparam logic [7:0] ADDR_SYS = 8'h2c;
  localparam logic [7:0] ADDR_IST = 8'h30;
  localparam logic [7:0] ADDR_IMSK = 8'h34;

  // timebase_control fields
  localparam int TBC_FLAG = 7;
  localparam int TBC_IE = 6;
  localparam int TBC_SEL_HI = 2;
  localparam int TBC_SEL_LO = 1;
  localparam int TBC_CLR = 0;

  // system_clock_control fields
  localparam int SYS_WAIT_HI = 1;
  localparam int SYS_WAIT_LO = 0;
  localparam int SYS_SCS = 2;
  localparam int SYS_STOP = 3;
  localparam int SYS_WDSRC = 4;
  localparam int SYS_READY = 5;
  localparam int SYS_OSC = 6;

  // Interrupt status / mask fields
  localparam int IRQ_W = 2;
  localparam int IST_IVL = 0;
  localparam int IST_WAIT = 1;

  // Reset values
  localparam logic [1:0] RST_IVL_SEL = 2'h0;
  localparam logic [1:0] RST_WAIT_SEL = 2'h3;
  localparam logic RST_SCS = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic flag;
    logic irq_en;
    logic [1:0] sel;
  } tbt_ctrl_t;

  typedef struct packed {
    logic [1:0] wait_sel;
    logic main_sel;
    logic stop_req;
    logic wd_src;
  } tbt_sys_t;

  typedef struct packed {
    logic wdt;
    logic buz;
    logic adc;
    logic lcd;
  } tbt_taps_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_HALT = 3'h2,
    ST_WAIT = 3'h4
  } tbt_state_t;

endpackage

// ---- core/tbt_tap_ovf.sv ----
// Module: carry-out detector on one of four selectable counter bits
`timescale 1ns/10ps
`default_nettype none
module tbt_tap_ovf #(
  parameter int CNT_W = 21,
  parameter int B0 = 0,
  parameter int B1 = 1,
  parameter int B2 = 2,
  parameter int B3 = 3
) (
  // Counter view
  input wire logic [CNT_W-1:0] cnt,
  input wire logic inc,
  // Tap choice
  input wire logic [1:0] sel,
  // Carry-out of chosen bit, valid in the incrementing cycle
  output logic ovf
);

  localparam logic [CNT_W-1:0] M0 = CNT_W'((64'h1 << (B0 + 1)) - 64'h1);
  localparam logic [CNT_W-1:0] M1 = CNT_W'((64'h1 << (B1 + 1)) - 64'h1);
  localparam logic [CNT_W-1:0] M2 = CNT_W'((64'h1 << (B2 + 1)) - 64'h1);
  localparam logic [CNT_W-1:0] M3 = CNT_W'((64'h1 << (B3 + 1)) - 64'h1);

  logic [CNT_W-1:0] mask;

  // Bit overflows when it and all bits below are ones as the counter steps
  always_comb begin
    case (sel)
      2'h0: mask = M0;
      2'h1: mask = M1;
      2'h2: mask = M2;
      default: mask = M3;
    endcase
    ovf = inc && ((cnt & mask) == mask);
  end

endmodule // tbt_tap_ovf
`default_nettype wire

// ---- core/tbt_timer.sv ----
// Module: timebase interval timer with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module tbt_timer #(
  parameter int CNT_W = tbt_pkg::CNT_W
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Wake-up request from outside (asynchronous pin)
  input wire logic wake_pin,
  // Interrupts
  output logic interval_interrupt_line,
  output logic irq,
  // Clock control and peripheral taps
  output logic main_clock_ready,
  output logic osc_enable,
  output logic wdt_counter_clear,
  output tbt_pkg::tbt_taps_t clk_taps
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tbt_pkg::tbt_ctrl_t ctrl;
  tbt_pkg::tbt_sys_t sys;
  tbt_pkg::tbt_state_t state;
  tbt_pkg::tbt_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [tbt_pkg::IRQ_W-1:0] irq_stat;
  logic [tbt_pkg::IRQ_W-1:0] irq_mask;
  logic div_ph;
  logic inc;
  logic ivl_ovf;
  logic wait_ovf;
  logic sw_clr;
  logic mode_clr;
  logic any_clr;
  logic wake_s1;
  logic wake_s2;
  logic wake_q;
  logic wake_rise;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic wr_ok;
  logic rd_req;
  logic addr_ok;
  logic [31:0] rd_data;
  logic wr_tbc;
  logic wr_sys;
  logic wr_ist;
  logic wr_imsk;
  logic osc_on;
  logic leave_main;

  // ----------------------------------------------------------------
  // AHB-Lite front end
  // ----------------------------------------------------------------

  // Zero wait states and OKAY only; the block never needs to stall the bus
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign addr_ok = (haddr[31:8] == 24'h0);
  assign rd_req = hsel && htrans[1] && hready && !hwrite;

  // Address phase captured for the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
      wr_ok <= 1'b0;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
      wr_ok <= addr_ok;
    end
  end

  // Write strobes for the data phase; unmapped addresses hit nothing
  assign wr_tbc = wr_pend && wr_ok && (wr_addr == tbt_pkg::ADDR_TBC);
  assign wr_sys = wr_pend && wr_ok && (wr_addr == tbt_pkg::ADDR_SYS);
  assign wr_ist = wr_pend && wr_ok && (wr_addr == tbt_pkg::ADDR_IST);
  assign wr_imsk = wr_pend && wr_ok && (wr_addr == tbt_pkg::ADDR_IMSK);

  // Read mux; reserved bits and unmapped words read zero
  always_comb begin
    rd_data = 32'h0;
    if (addr_ok) begin
      case (haddr[7:0])
        tbt_pkg::ADDR_TBC: begin
          rd_data[tbt_pkg::TBC_FLAG] = ctrl.flag;
          rd_data[tbt_pkg::TBC_IE] = ctrl.irq_en;
          rd_data[tbt_pkg::TBC_SEL_HI:tbt_pkg::TBC_SEL_LO] = ctrl.sel;
          rd_data[tbt_pkg::TBC_CLR] = 1'b1;
        end
        tbt_pkg::ADDR_SYS: begin
          rd_data[tbt_pkg::SYS_WAIT_HI:tbt_pkg::SYS_WAIT_LO] = sys.wait_sel;
          rd_data[tbt_pkg::SYS_SCS] = sys.main_sel;
          rd_data[tbt_pkg::SYS_STOP] = sys.stop_req;
          rd_data[tbt_pkg::SYS_WDSRC] = sys.wd_src;
          rd_data[tbt_pkg::SYS_READY] = main_clock_ready;
          rd_data[tbt_pkg::SYS_OSC] = osc_on;
        end
        tbt_pkg::ADDR_IST: rd_data[tbt_pkg::IRQ_W-1:0] = irq_stat;
        tbt_pkg::ADDR_IMSK: rd_data[tbt_pkg::IRQ_W-1:0] = irq_mask;
        default: rd_data = 32'h0;
      endcase
    end
  end

  // Read data registered at the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (rd_req) begin
      hrdata <= rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Wake-up pin synchroniser
  // ----------------------------------------------------------------

  // Two flops before use; the edge detector compares the second with its delayed copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      wake_s1 <= wake_pin;
      wake_s2 <= wake_s1;
      wake_q <= wake_s2;
    end
  end

  assign wake_rise = wake_s2 && !wake_q;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------

  // Interval enable and select; the flag lives in its own process
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl.irq_en <= 1'b0;
      ctrl.sel <= tbt_pkg::RST_IVL_SEL;
    end else if (wr_tbc) begin
      ctrl.irq_en <= hwdata[tbt_pkg::TBC_IE];
      ctrl.sel <= hwdata[tbt_pkg::TBC_SEL_HI:tbt_pkg::TBC_SEL_LO];
    end
  end

  // Clear bit is a strobe only: zero clears, one is ignored, nothing is stored
  assign sw_clr = wr_tbc && !hwdata[tbt_pkg::TBC_CLR];

  // System clock settings; a wake-up edge ends stop mode from hardware
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys.wait_sel <= tbt_pkg::RST_WAIT_SEL;
      sys.main_sel <= tbt_pkg::RST_SCS;
      sys.stop_req <= 1'b0;
      sys.wd_src <= 1'b0;
    end else begin
      if (wr_sys) begin
        sys.wait_sel <= hwdata[tbt_pkg::SYS_WAIT_HI:tbt_pkg::SYS_WAIT_LO];
        sys.main_sel <= hwdata[tbt_pkg::SYS_SCS];
        sys.wd_src <= hwdata[tbt_pkg::SYS_WDSRC];
        sys.stop_req <= hwdata[tbt_pkg::SYS_STOP];
      end
      if (wake_rise && sys.stop_req) begin
        sys.stop_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator mode sequencer
  // ----------------------------------------------------------------

  // Oscillator is off while stop is requested or the subclock is chosen
  assign leave_main = sys.stop_req || !sys.main_sel;

  always_comb begin
    next_state = state;
    case (state)
      tbt_pkg::ST_RUN: begin
        if (leave_main) begin
          next_state = tbt_pkg::ST_HALT;
        end
      end
      tbt_pkg::ST_HALT: begin
        if (!leave_main) begin
          next_state = tbt_pkg::ST_WAIT;
        end
      end
      tbt_pkg::ST_WAIT: begin
        if (leave_main) begin
          next_state = tbt_pkg::ST_HALT;
        end else if (wait_ovf) begin
          next_state = tbt_pkg::ST_RUN;
        end
      end
      default: next_state = tbt_pkg::ST_HALT;
    endcase
  end

  // Reset behaves as power-on: oscillator starts, so a full wait is timed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= tbt_pkg::ST_WAIT;
    end else begin
      state <= next_state;
    end
  end

  assign osc_on = (state != tbt_pkg::ST_HALT);
  assign osc_enable = osc_on;
  assign main_clock_ready = (state == tbt_pkg::ST_RUN);

  // Entering halt clears the counter; it is already zero when halt ends,
  // so the wait after wake-up always counts from zero
  assign mode_clr = (state != tbt_pkg::ST_HALT) && (next_state == tbt_pkg::ST_HALT);
  assign any_clr = sw_clr || mode_clr;

  // ----------------------------------------------------------------
  // Count clock divider and counter
  // ----------------------------------------------------------------

  // One-cycle enable every second hclk; the divider stays in step with the
  // counter clear so the first count after a clear is a full count period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ph <= 1'b0;
    end else if (any_clr || !osc_on) begin
      div_ph <= 1'b0;
    end else begin
      div_ph <= !div_ph;
    end
  end

  assign inc = osc_on && div_ph;

  // 21-bit up-counter; a clear beats a step in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
    end else if (any_clr) begin
      cnt <= '0;
    end else if (inc) begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Tap overflow detectors
  // ----------------------------------------------------------------

  // Interval tap: select 11 is bit 19, i.e. 2^21 oscillator periods
  tbt_tap_ovf #(
    .CNT_W(CNT_W),
    .B0(tbt_pkg::IVL_BIT0),
    .B1(tbt_pkg::IVL_BIT1),
    .B2(tbt_pkg::IVL_BIT2),
    .B3(tbt_pkg::IVL_BIT3)
  ) u_ivl_tap (
    .cnt(cnt),
    .inc(inc),
    .sel(ctrl.sel),
    .ovf(ivl_ovf)
  );

  // Stabilisation tap chosen by the wait select field
  tbt_tap_ovf #(
    .CNT_W(CNT_W),
    .B0(tbt_pkg::WAIT_BIT0),
    .B1(tbt_pkg::WAIT_BIT1),
    .B2(tbt_pkg::WAIT_BIT2),
    .B3(tbt_pkg::WAIT_BIT3)
  ) u_wait_tap (
    .cnt(cnt),
    .inc(inc),
    .sel(sys.wait_sel),
    .ovf(wait_ovf)
  );

  // ----------------------------------------------------------------
  // Interval flag and interrupts
  // ----------------------------------------------------------------

  // Set beats a software clear; a counter clear in the same cycle
  // suppresses the set, since the overflow never really happened
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl.flag <= 1'b0;
    end else if (ivl_ovf && !any_clr) begin
      ctrl.flag <= 1'b1;
    end else if (wr_tbc && !hwdata[tbt_pkg::TBC_FLAG]) begin
      ctrl.flag <= 1'b0;
    end
  end

  // Level request; software must clear the flag or the enable to drop it
  assign interval_interrupt_line = ctrl.flag && ctrl.irq_en;

  // Sticky event bits, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
    end else begin
      if (wr_ist) begin
        irq_stat <= irq_stat & ~hwdata[tbt_pkg::IRQ_W-1:0];
      end
      if (ivl_ovf && !any_clr) begin
        irq_stat[tbt_pkg::IST_IVL] <= 1'b1;
      end
      if (state == tbt_pkg::ST_WAIT && next_state == tbt_pkg::ST_RUN) begin
        irq_stat[tbt_pkg::IST_WAIT] <= 1'b1;
      end
    end
  end

  // Mask register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= '0;
    end else if (wr_imsk) begin
      irq_mask <= hwdata[tbt_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // Peripheral clock taps
  // ----------------------------------------------------------------

  // Taps are counter bits, so any clear restarts them low mid-period;
  // consumers must tolerate a short high or long low phase
  always_comb begin
    clk_taps.wdt = cnt[tbt_pkg::TAP_WDT];
    clk_taps.buz = cnt[tbt_pkg::TAP_BUZ];
    clk_taps.adc = cnt[tbt_pkg::TAP_ADC];
    clk_taps.lcd = cnt[tbt_pkg::TAP_LCD];
  end

  // Watchdog follows our clears only while it counts our tap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_counter_clear <= 1'b0;
    end else begin
      wdt_counter_clear <= any_clr && !sys.wd_src;
    end
  end

endmodule // tbt_timer
`default_nettype wire

// ---- tb/tbt_timer_chk.sv ----
// Checker: port-level assertions for the timebase interval timer
`timescale 1ns/10ps
`default_nettype none
module tbt_timer_chk #(
  parameter int CNT_W = 21
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Timer outputs
  input wire logic interval_interrupt_line,
  input wire logic main_clock_ready,
  input wire logic osc_enable,
  input wire logic wdt_counter_clear,
  input wire tbt_pkg::tbt_taps_t clk_taps
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_req;
  // Read address phase is the only thing allowed to reload read data
  assign rd_req = hsel && htrans[1] && !hwrite && hready;
  a_bus_okay: assert property (hreadyout && !hresp) else $error("slave not ready or not OKAY");
  a_rd_stands: assert property ($changed(hrdata) |-> $past(rd_req)) else $error("read data moved without a read");
  a_halt_ready: assert property (!osc_enable |-> !main_clock_ready)
    else $error("main clock ready while oscillator off");
  a_halt_taps: assert property (!osc_enable && $past(!osc_enable) |-> clk_taps == 4'h0)
    else $error("clock taps not held low while halted");
  a_wdt_pulse: assert property (wdt_counter_clear |=> !wdt_counter_clear)
    else $error("watchdog clear longer than one cycle");
  a_wake_wait: assert property ($rose(osc_enable) |-> !main_clock_ready [*8])
    else $error("main clock ready without stabilisation wait");
  // A clear may cut a high phase short, so only the low phase has a floor
  a_tap_slow: assert property ($fell(clk_taps.wdt) |=> !clk_taps.wdt [*8])
    else $error("watchdog tap toggles too fast");
  a_clr_taps: assert property (wdt_counter_clear |-> clk_taps == 4'h0)
    else $error("clock taps not restarted low after a clear");
  a_ready_osc: assert property ($rose(main_clock_ready) |-> osc_enable && $past(osc_enable))
    else $error("ready rose without running oscillator");
  c_ivl: cover property ($rose(interval_interrupt_line));
  c_ready: cover property ($rose(main_clock_ready));
  c_wdclr: cover property (wdt_counter_clear);
endmodule // tbt_timer_chk

bind tbt_timer tbt_timer_chk #(.CNT_W(CNT_W)) chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .interval_interrupt_line(interval_interrupt_line), .main_clock_ready(main_clock_ready),
  .osc_enable(osc_enable), .wdt_counter_clear(wdt_counter_clear), .clk_taps(clk_taps));
`default_nettype wire

// ---- tb/tbt_periph_model.sv ----
// Partner: interrupt controller and watchdog consumer seen from the timer
`timescale 1ns/10ps
`default_nettype none
module tbt_periph_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // From the timer
  input wire logic interval_interrupt_line,
  input wire logic wdt_counter_clear,
  // Event counts
  output var int n_irq,
  output var int n_wd_clr
);
  logic line_q;
  // Level request is taken once per rising edge, like a CPU entering service
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_q <= 1'b0;
      n_irq <= 0;
      n_wd_clr <= 0;
    end else begin
      line_q <= interval_interrupt_line;
      if (interval_interrupt_line && !line_q) n_irq <= n_irq + 1;
      if (wdt_counter_clear) n_wd_clr <= n_wd_clr + 1; // Watchdog restarts its count
    end
  end
endmodule // tbt_periph_model
`default_nettype wire

// ---- tb/test_timebase_interval_timer.sv ----
// Testbench: self-checking bench for the timebase interval timer
`timescale 1ns/10ps
`default_nettype none
module test_timebase_interval_timer;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, wake_pin = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic hready, hreadyout, hresp, interval_interrupt_line, irq, main_clock_ready, osc_enable, wdt_counter_clear;
  tbt_pkg::tbt_taps_t clk_taps;
  int n_fail = 0, n_checks = 0, n, n_irq, n_wd_clr, n0;
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  tbt_timer tbt_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .wake_pin(wake_pin), .interval_interrupt_line(interval_interrupt_line), .irq(irq),
    .main_clock_ready(main_clock_ready), .osc_enable(osc_enable), .wdt_counter_clear(wdt_counter_clear),
    .clk_taps(clk_taps));
  tbt_periph_model tbt_periph_model_i (.hclk(hclk), .hresetn(hresetn),
    .interval_interrupt_line(interval_interrupt_line), .wdt_counter_clear(wdt_counter_clear),
    .n_irq(n_irq), .n_wd_clr(n_wd_clr));
  // 40 MHz clock
  always #12.5 hclk = ~hclk;
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic in_range(input string what, input int v, input int lo, input int hi);
    check(what, {31'h0, v >= lo && v <= hi}, 32'h1);
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait for one ready edge; a hung slave ends the run
  task automatic wait_rdy;
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  // Counts cycles until the interval line (0) or main clock ready (1) goes high
  task automatic wait_hi(input int which, input int bound, output int cyc);
    for (cyc = 0; cyc < bound; cyc++) begin
      @(posedge hclk);
      if ((which == 0 ? interval_interrupt_line : main_clock_ready) === 1'b1) break;
    end
    if (cyc == bound) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_vals;
    rdchk("ctrl reset", tbt_pkg::ADDR_TBC, 32'h01);
    rdchk("sys reset", tbt_pkg::ADDR_SYS, 32'h47);
    rdchk("mask reset", tbt_pkg::ADDR_IMSK, 32'h0);
    bus(1'b1, 8'h40, 32'hff);
    rdchk("unmapped", 8'h40, 32'h0);
  endtask
  // Stop entry halts and clears; wake counts the short wait from zero
  task automatic t_stop_wake;
    n0 = n_wd_clr;
    bus(1'b1, tbt_pkg::ADDR_SYS, 32'h0c); // Shortest wait suits the ideal oscillator of the bench
    repeat (3) @(posedge hclk);
    check("osc off", {31'h0, osc_enable}, 32'h0);
    check("wd clear", n_wd_clr, n0 + 1);
    rdchk("sys stop", tbt_pkg::ADDR_SYS, 32'h0c);
    wake_pin <= 1'b1;
    wait_hi(1, 20000, n);
    wake_pin <= 1'b0;
    in_range("wake wait", n, 16384, 16400);
    rdchk("sys run", tbt_pkg::ADDR_SYS, 32'h64);
    // Counter runs during the wait, so interval events are logged as well
    rdchk("stab status", tbt_pkg::ADDR_IST, 32'h03);
  endtask
  task automatic t_irq_mask;
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, tbt_pkg::ADDR_IMSK, 32'h02);
    repeat (2) @(posedge hclk);
    check("irq on", {31'h0, irq}, 32'h1);
    bus(1'b1, tbt_pkg::ADDR_IST, 32'h02);
    repeat (2) @(posedge hclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdchk("status clear", tbt_pkg::ADDR_IST, 32'h01);
  endtask
  task automatic t_subclock;
    n0 = n_wd_clr;
    bus(1'b1, tbt_pkg::ADDR_SYS, 32'h00);
    repeat (3) @(posedge hclk);
    check("sub osc off", {31'h0, osc_enable}, 32'h0);
    check("sub wd clear", n_wd_clr, n0 + 1);
    bus(1'b1, tbt_pkg::ADDR_SYS, 32'h04);
    wait_hi(1, 20000, n);
    in_range("sub wait", n, 16384, 16400);
  endtask
  // Interval select 00 is 2^13 cycles, measured from each clear
  task automatic t_interval;
    n0 = n_irq;
    // Enable, select 00, clear flag and counter; then drop stale status
    bus(1'b1, tbt_pkg::ADDR_TBC, 32'h40);
    bus(1'b1, tbt_pkg::ADDR_IST, 32'h03);
    repeat (2) @(posedge hclk);
    check("taps restart", clk_taps, 32'h0);
    wait_hi(0, 9000, n);
    in_range("interval", n, 8188, 8200);
    // Flag clear only; the counter keeps running
    bus(1'b1, tbt_pkg::ADDR_TBC, 32'h41);
    repeat (2) @(posedge hclk);
    check("flag cleared", {31'h0, interval_interrupt_line}, 32'h0);
    repeat (4000) @(posedge hclk);
    bus(1'b1, tbt_pkg::ADDR_TBC, 32'h40);
    wait_hi(0, 9000, n);
    in_range("after clear", n, 8188, 8200);
    rdchk("flag set", tbt_pkg::ADDR_TBC, 32'hc1);
    bus(1'b1, tbt_pkg::ADDR_TBC, 32'hc1);
    rdchk("write one", tbt_pkg::ADDR_TBC, 32'hc1);
    bus(1'b1, tbt_pkg::ADDR_TBC, 32'h81);
    repeat (2) @(posedge hclk);
    check("line gated", {31'h0, interval_interrupt_line}, 32'h0);
    rdchk("flag held", tbt_pkg::ADDR_TBC, 32'h81);
    rdchk("ivl status", tbt_pkg::ADDR_IST, 32'h01);
    check("irq count", n_irq, n0 + 2);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_vals();
    t_stop_wake();
    t_irq_mask();
    t_subclock();
    t_interval();
    tally_and_finish();
  end
  // Run limit
  initial begin
    #2500000;
    n_fail++;
    tally_and_finish();
  end
endmodule // test_timebase_interval_timer
`default_nettype wire
